// [src/crol_pkg.sv]
// Package for the clock and reset option logic: encodings, counts, carriers
package crol_pkg;
	// Fixed divided frequency selections: reference divided by 2**sel
	localparam logic [3:0] FIX_16M = 4'h0;
	localparam logic [3:0] FIX_62K5 = 4'h8;
	localparam int FIX_LAST = 8;
	// Guard frequency bands
	typedef enum logic [2:0] {
		band_very_low,
		band_low,
		band_mid,
		band_mid_high,
		band_high
	} crol_band_t;
	// Band limits in kHz, lower and upper
	localparam logic [15:0] VLOW_LO_KHZ = 16'h0020;
	localparam logic [15:0] VLOW_HI_KHZ = 16'h0064;
	localparam logic [15:0] LOW_LO_KHZ = 16'h03E8;
	localparam logic [15:0] LOW_HI_KHZ = 16'h07D0;
	localparam logic [15:0] MID_LO_KHZ = 16'h07D0;
	localparam logic [15:0] MID_HI_KHZ = 16'h0FA0;
	localparam logic [15:0] MIDH_LO_KHZ = 16'h0FA0;
	localparam logic [15:0] MIDH_HI_KHZ = 16'h1F40;
	localparam logic [15:0] HIGH_LO_KHZ = 16'h1F40;
	localparam logic [15:0] HIGH_HI_KHZ = 16'h3E80;
	// Custom synthesizer limits, in kHz
	localparam logic [15:0] SYN_MIN_KHZ = 16'h0020;
	localparam logic [15:0] SYN_MAX_KHZ = 16'h3E80;
	// Hold lengths in CPU cycles
	localparam logic [12:0] HOLD_LONG = 13'h1000;
	localparam logic [12:0] HOLD_SHORT = 13'h0100;
	// Voltage detection selection and threshold in millivolts
	typedef enum logic [1:0] {
		det_off,
		det_highest,
		det_medium,
		det_lowest
	} crol_det_t;
	localparam logic [11:0] DET_THRESH_MV = 12'h5DC;
	// Option bundle
	typedef struct packed {
		logic use_custom;
		logic [3:0] fixed_sel;
		logic [15:0] custom_freq_entry;
		logic clock_guard_enable;
		crol_band_t guard_freq_band;
		logic pll_enable;
		logic reset_delay_select;
		crol_det_t voltage_detect_select;
		logic watchdog_halt_action;
		logic watchdog_start_select;
	} crol_opt_t;
	// Clock steering outputs
	typedef struct packed {
		logic [3:0] fixed_div;
		logic synth_load;
		logic [15:0] synth_khz;
		logic backup_select;
		logic pll_on;
		logic pll_out_of_spec;
	} crol_clk_t;
endpackage : crol_pkg

// [src/crol_top.sv]
// Clock and reset option logic top module
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// RQ1 - Fixed divided frequency, nine choices
// RQ2 - Programmable synthesizer, only generable values accepted
// RQ3 - Guard option enables filter and backup together
// RQ4 - Out of band frequency switches to backup
// RQ5 - Five guard frequency bands encoded
// RQ6 - PLL doubles clock, valid 2 to 4 MHz
// RQ7 - Hold core 4096 or 256 cycles
// RQ8 - Detection off disables both detectors
// RQ9 - Three thresholds all enable, same 1.5 V
// RQ10 - Halt with active watchdog resets if selected
// RQ11 - Watchdog started by software or hardware
// RQ12 - Low voltage detector off in halt
// RQ13 - PLL off passes clock unmultiplied
module crol_top (
	input wire logic clk,
	input wire logic srst,
	input wire crol_pkg::crol_opt_t opt,
	input wire logic [15:0] meas_khz,
	input wire logic meas_valid,
	input wire logic halt_exec,
	input wire logic halt_exit,
	input wire logic active_halt,
	input wire logic watchdog_sw_start,
	output crol_pkg::crol_clk_t clk_ctl,
	output logic synth_reject,
	output logic filter_enable,
	output logic core_hold,
	output logic low_volt_enable,
	output logic aux_volt_enable,
	output logic [11:0] det_thresh_mv,
	output logic watchdog_active,
	output logic chip_reset
);
	crol_pkg::crol_clk_t clk_d, clk_q;
	logic rej_d, rej_q, filt_d, filt_q;
	logic [12:0] hold_cnt_d, hold_cnt_q;
	logic hold_d, hold_q;
	logic lowv_d, lowv_q, auxv_d, auxv_q;
	logic [11:0] thr_d, thr_q;
	logic dog_d, dog_q, rst_d, rst_q, halted_d, halted_q;
	logic [15:0] lo_khz, hi_khz;
	logic in_band, syn_ok;

	// Band limits for the selected guard band
	always_comb begin
		lo_khz = crol_pkg::HIGH_LO_KHZ;
		hi_khz = crol_pkg::HIGH_HI_KHZ;
		case (opt.guard_freq_band) // see RQ5
			crol_pkg::band_very_low: begin
				lo_khz = crol_pkg::VLOW_LO_KHZ;
				hi_khz = crol_pkg::VLOW_HI_KHZ;
			end
			crol_pkg::band_low: begin
				lo_khz = crol_pkg::LOW_LO_KHZ;
				hi_khz = crol_pkg::LOW_HI_KHZ;
			end
			crol_pkg::band_mid: begin
				lo_khz = crol_pkg::MID_LO_KHZ;
				hi_khz = crol_pkg::MID_HI_KHZ;
			end
			crol_pkg::band_mid_high: begin
				lo_khz = crol_pkg::MIDH_LO_KHZ;
				hi_khz = crol_pkg::MIDH_HI_KHZ;
			end
			default: begin
				lo_khz = crol_pkg::HIGH_LO_KHZ;
				hi_khz = crol_pkg::HIGH_HI_KHZ;
			end
		endcase
		in_band = (meas_khz >= lo_khz) && (meas_khz <= hi_khz);
		// Synthesizer makes whole kHz within its span only
		syn_ok = (opt.custom_freq_entry >= crol_pkg::SYN_MIN_KHZ)
			&& (opt.custom_freq_entry <= crol_pkg::SYN_MAX_KHZ); // see RQ2
	end

	// Clock source steering
	always_comb begin
		clk_d = clk_q;
		rej_d = 1'b0;
		clk_d.fixed_div = (opt.fixed_sel > crol_pkg::FIX_62K5) ? crol_pkg::FIX_62K5 : opt.fixed_sel; // see RQ1
		clk_d.synth_load = 1'b0;
		if (opt.use_custom) begin
			if (syn_ok) begin
				clk_d.synth_khz = opt.custom_freq_entry; // see RQ2
				clk_d.synth_load = (opt.custom_freq_entry != clk_q.synth_khz);
			end else begin
				rej_d = 1'b1; // see RQ2
			end
		end
		filt_d = opt.clock_guard_enable; // see RQ3
		if (!opt.clock_guard_enable) begin
			clk_d.backup_select = 1'b0; // see RQ3
		end else if (meas_valid && !in_band) begin
			clk_d.backup_select = 1'b1; // see RQ4
		end
		clk_d.pll_on = opt.pll_enable; // see RQ6 RQ13
		clk_d.pll_out_of_spec = opt.pll_enable
			&& ((meas_khz < crol_pkg::MID_LO_KHZ) || (meas_khz > crol_pkg::MID_HI_KHZ)); // see RQ6
	end

	// Core hold counter for reset and halt exit
	always_comb begin
		hold_cnt_d = hold_cnt_q;
		hold_d = hold_q;
		halted_d = halted_q;
		if (halt_exec) begin
			halted_d = 1'b1;
		end
		if (halted_q && halt_exit) begin
			halted_d = 1'b0;
			hold_d = 1'b1;
			hold_cnt_d = opt.reset_delay_select ? crol_pkg::HOLD_SHORT : crol_pkg::HOLD_LONG; // see RQ7
		end else if (hold_q) begin
			if (hold_cnt_q == 13'h0001) begin
				hold_d = 1'b0;
			end
			hold_cnt_d = hold_cnt_q - 13'h0001; // see RQ7
		end
	end

	// Voltage detectors and watchdog
	always_comb begin
		auxv_d = (opt.voltage_detect_select != crol_pkg::det_off); // see RQ8 RQ9
		lowv_d = auxv_d && !halted_q && !active_halt && !halt_exec; // see RQ12
		thr_d = crol_pkg::DET_THRESH_MV; // see RQ9
		dog_d = dog_q || watchdog_sw_start; // see RQ11
		rst_d = halt_exec && dog_q && opt.watchdog_halt_action; // see RQ10
	end

	// Registers
	always_ff @(posedge clk) begin
		if (srst || rst_q) begin
			clk_q <= '0;
			rej_q <= 1'b0;
			filt_q <= 1'b0;
			hold_q <= 1'b1;
			// Reset phase hold length; short when option set
			hold_cnt_q <= opt.reset_delay_select ? crol_pkg::HOLD_SHORT : crol_pkg::HOLD_LONG; // see RQ7
			halted_q <= 1'b0;
			lowv_q <= 1'b0;
			auxv_q <= 1'b0;
			thr_q <= crol_pkg::DET_THRESH_MV;
			dog_q <= !opt.watchdog_start_select; // see RQ11
			rst_q <= 1'b0;
		end else begin
			clk_q <= clk_d;
			rej_q <= rej_d;
			filt_q <= filt_d;
			hold_q <= hold_d;
			hold_cnt_q <= hold_cnt_d;
			halted_q <= halted_d;
			lowv_q <= lowv_d;
			auxv_q <= auxv_d;
			thr_q <= thr_d;
			dog_q <= dog_d;
			rst_q <= rst_d;
		end
	end

	assign clk_ctl = clk_q;
	assign synth_reject = rej_q;
	assign filter_enable = filt_q;
	assign core_hold = hold_q;
	assign low_volt_enable = lowv_q;
	assign aux_volt_enable = auxv_q;
	assign det_thresh_mv = thr_q;
	assign watchdog_active = dog_q;
	assign chip_reset = rst_q;

	// Checker helper: cycles in the current core hold run
	logic [12:0] run_len_d, run_len_q;
	always_comb begin
		run_len_d = core_hold ? (run_len_q + 13'h0001) : 13'h0000;
	end
	always_ff @(posedge clk) begin
		if (srst || rst_q) begin
			run_len_q <= 13'h0000;
		end else begin
			run_len_q <= run_len_d;
		end
	end

	// Halt with running watchdog and reset option gives chip reset
	a_halt_reset: assert property (@(posedge clk) disable iff (srst) // see RQ10
		(halt_exec && dog_q && opt.watchdog_halt_action && !rst_q) |=> chip_reset)
		else $error("halt did not reset chip");
	a_halt_noreset: assert property (@(posedge clk) disable iff (srst) // see RQ10
		(!opt.watchdog_halt_action) |=> !chip_reset)
		else $error("chip reset without reset option");
	a_guard_switch: assert property (@(posedge clk) disable iff (srst) // see RQ4
		(opt.clock_guard_enable && meas_valid && !in_band && !rst_q) |=> clk_ctl.backup_select)
		else $error("no switch to backup");
	a_guard_off: assert property (@(posedge clk) disable iff (srst) // see RQ3
		(!opt.clock_guard_enable) |=> (!clk_ctl.backup_select && !filter_enable))
		else $error("guard off but active");
	a_det_off: assert property (@(posedge clk) disable iff (srst) // see RQ8
		(opt.voltage_detect_select == crol_pkg::det_off)
		|=> (!low_volt_enable && !aux_volt_enable))
		else $error("detectors on while off");
	a_det_on: assert property (@(posedge clk) disable iff (srst) // see RQ9
		(opt.voltage_detect_select != crol_pkg::det_off && !rst_q)
		|=> (aux_volt_enable && det_thresh_mv == 12'h5DC))
		else $error("detector threshold wrong");
	a_lowv_halt: assert property (@(posedge clk) disable iff (srst) // see RQ12
		(active_halt || halt_exec) |=> !low_volt_enable)
		else $error("low voltage detector on in halt");
	sequence s_short_exit;
		halted_q && halt_exit && opt.reset_delay_select && !rst_q;
	endsequence
	// Short hold: 256 held cycles counted by the helper, then release
	a_hold_short: assert property (@(posedge clk) disable iff (srst) // see RQ7
		s_short_exit |=> ##256 (!core_hold && run_len_q == crol_pkg::HOLD_SHORT))
		else $error("short hold length wrong");
	a_hold_run: assert property (@(posedge clk) disable iff (srst) // see RQ7
		$fell(core_hold) |-> (run_len_q == crol_pkg::HOLD_SHORT || run_len_q == crol_pkg::HOLD_LONG))
		else $error("hold run length wrong");
	a_pll_pass: assert property (@(posedge clk) disable iff (srst) // see RQ13
		(!opt.pll_enable) |=> (!clk_ctl.pll_on && !clk_ctl.pll_out_of_spec))
		else $error("pll active while off");
	a_synth_reject: assert property (@(posedge clk) disable iff (srst) // see RQ2
		(opt.use_custom && !syn_ok && !rst_q) |=> (synth_reject && !clk_ctl.synth_load))
		else $error("bad synth value accepted");
endmodule // crol_top
`default_nettype wire

// [test/crol_osc_model.sv]
// External oscillator model feeding frequency measurements
`timescale 1ns/10ps
`default_nettype none
module crol_osc_model (
	input wire logic clk,
	input wire logic run,
	input wire logic [15:0] freq_khz,
	output logic [15:0] meas_khz,
	output logic meas_valid
);
	// Measurement lags one cycle, inverse of the setting when stopped
	always @(posedge clk) begin
		meas_valid <= run;
		meas_khz <= run ? freq_khz : ~freq_khz;
	end
endmodule // crol_osc_model
`default_nettype wire

// [test/tb_crol_top.sv]
// Testbench for the clock and reset option logic
`timescale 1ns/10ps
`default_nettype none
module tb_crol_top;
	logic clk = 1'b0, srst = 1'b1, halt_exec = 1'b0, halt_exit = 1'b0, active_halt = 1'b0;
	logic watchdog_sw_start = 1'b0, run = 1'b1, meas_valid, synth_reject, filter_enable, core_hold;
	logic low_volt_enable, aux_volt_enable, watchdog_active, chip_reset;
	logic [15:0] freq = 16'h0BB8, meas_khz;
	logic [11:0] det_thresh_mv;
	crol_pkg::crol_opt_t opt = '0;
	crol_pkg::crol_clk_t clk_ctl;
	int fail_count = 0, n_checks = 0, n;
	// Guard band edges per band code
	logic [15:0] band_lo [5] = '{crol_pkg::VLOW_LO_KHZ, crol_pkg::LOW_LO_KHZ, crol_pkg::MID_LO_KHZ,
		crol_pkg::MIDH_LO_KHZ, crol_pkg::HIGH_LO_KHZ};
	logic [15:0] band_hi [5] = '{crol_pkg::VLOW_HI_KHZ, crol_pkg::LOW_HI_KHZ, crol_pkg::MID_HI_KHZ,
		crol_pkg::MIDH_HI_KHZ, crol_pkg::HIGH_HI_KHZ};
	// Clock
	always #10 clk = ~clk;
	crol_osc_model i_crol_osc_model (.clk(clk), .run(run), .freq_khz(freq), .meas_khz(meas_khz),
		.meas_valid(meas_valid));
	crol_top i_crol_top (.clk(clk), .srst(srst), .opt(opt), .meas_khz(meas_khz), .meas_valid(meas_valid),
		.halt_exec(halt_exec), .halt_exit(halt_exit), .active_halt(active_halt),
		.watchdog_sw_start(watchdog_sw_start), .clk_ctl(clk_ctl), .synth_reject(synth_reject),
		.filter_enable(filter_enable), .core_hold(core_hold), .low_volt_enable(low_volt_enable),
		.aux_volt_enable(aux_volt_enable), .det_thresh_mv(det_thresh_mv),
		.watchdog_active(watchdog_active), .chip_reset(chip_reset));
	task chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
		n_checks++;
		if (seen !== exp) begin
			$display("BAD %s exp %h seen %h", nm, exp, seen);
			fail_count++;
		end
	endtask
	task step(input int k);
		repeat (k) @(negedge clk);
	endtask
	task hold_len;
		n = 0;
		while (core_hold === 1'b1 && n < 5000) begin
			step(1);
			n++;
		end
		chk(16'(n), 16'(crol_pkg::HOLD_SHORT), "hold");
	endtask
	task wrap_up;
		$display("checks %0d fails %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		wrap_up();
	end
	// Test sequence
	initial begin
		opt.reset_delay_select = 1'b1;
		opt.watchdog_start_select = 1'b1;
		step(2);
		srst = 1'b0;
		hold_len();
		chk(watchdog_active, 16'h0000, "wdg");
		$display("reset test done");
		for (int i = 0; i < 4; i++) begin
			opt.voltage_detect_select = crol_pkg::crol_det_t'(i);
			step(2);
			chk({low_volt_enable, aux_volt_enable}, (i == 0) ? 16'h0000 : 16'h0003, "vd");
			chk(det_thresh_mv, 16'h05DC, "thr");
		end
		for (int i = 0; i <= 9; i++) begin
			opt.fixed_sel = (i == 9) ? 4'hF : 4'(i);
			step(2);
			chk(clk_ctl.fixed_div, (i == 9) ? 16'h0008 : 16'(i), "div");
		end
		opt.use_custom = 1'b1;
		opt.custom_freq_entry = 16'h3E80;
		step(1);
		chk(clk_ctl.synth_load, 16'h0001, "load");
		step(1);
		chk(clk_ctl.synth_load, 16'h0000, "once");
		chk(synth_reject, 16'h0000, "acc");
		chk(clk_ctl.synth_khz, 16'h3E80, "syn");
		opt.custom_freq_entry = 16'h001F;
		step(2);
		chk({synth_reject, clk_ctl.synth_load}, 16'h0002, "rej");
		chk(clk_ctl.synth_khz, 16'h3E80, "keep");
		$display("clock source test done");
		opt.clock_guard_enable = 1'b1;
		opt.guard_freq_band = crol_pkg::band_mid;
		opt.pll_enable = 1'b1;
		step(3);
		chk({filter_enable, clk_ctl.backup_select, clk_ctl.pll_on, clk_ctl.pll_out_of_spec}, 16'h000A, "in");
		run = 1'b0;
		step(3);
		chk(clk_ctl.backup_select, 16'h0000, "stop");
		run = 1'b1;
		step(2);
		freq = 16'h1388;
		step(3);
		chk({clk_ctl.backup_select, clk_ctl.pll_out_of_spec}, 16'h0003, "out");
		freq = 16'h0BB8;
		opt.pll_enable = 1'b0;
		step(3);
		chk({clk_ctl.backup_select, clk_ctl.pll_on}, 16'h0002, "stk");
		opt.clock_guard_enable = 1'b0;
		step(3);
		chk({filter_enable, clk_ctl.backup_select}, 16'h0000, "off");
		for (int b = 0; b < 5; b++) begin
			opt.clock_guard_enable = 1'b0;
			opt.guard_freq_band = crol_pkg::crol_band_t'(b);
			freq = band_lo[b];
			step(3);
			opt.clock_guard_enable = 1'b1;
			step(3);
			chk(clk_ctl.backup_select, 16'h0000, "blo");
			freq = band_hi[b];
			step(3);
			chk(clk_ctl.backup_select, 16'h0000, "bhi");
			freq = band_hi[b] + 16'h0001;
			step(3);
			chk(clk_ctl.backup_select, 16'h0001, "bout");
		end
		$display("guard test done");
		opt.voltage_detect_select = crol_pkg::det_highest;
		active_halt = 1'b1;
		step(2);
		chk(low_volt_enable, 16'h0000, "ah");
		active_halt = 1'b0;
		watchdog_sw_start = 1'b1;
		step(1);
		chk(low_volt_enable, 16'h0001, "lv");
		watchdog_sw_start = 1'b0;
		halt_exec = 1'b1;
		step(1);
		halt_exec = 1'b0;
		chk({watchdog_active, chip_reset, low_volt_enable}, 16'h0004, "nr");
		halt_exit = 1'b1;
		step(1);
		halt_exit = 1'b0;
		hold_len();
		opt.watchdog_halt_action = 1'b1;
		halt_exec = 1'b1;
		step(1);
		halt_exec = 1'b0;
		chk(chip_reset, 16'h0001, "rst");
		step(1);
		chk({core_hold, watchdog_active, chip_reset}, 16'h0004, "rh");
		hold_len();
		$display("halt test done");
		wrap_up();
	end
endmodule // tb_crol_top
`default_nettype wire
